//--- rtl/host_port_regs.vh
/*
  Constants for the parallel host port: bus and token widths, the token
  control bit position, cycle counts and reset values.
  Assumes inclusion by bare name from rtl/ design files.
*/
`ifndef HOST_PORT_REGS_VH
`define HOST_PORT_REGS_VH

// ----------------------------------------------------------------
// Widths and fields
// ----------------------------------------------------------------
`define HP_ADDR_W 5
`define HP_DATA_W 16
`define HP_TOKEN_W 9
`define HP_TOKEN_CTRL_BIT 8

// ----------------------------------------------------------------
// Access timing (host bus cycles)
// ----------------------------------------------------------------
`define HP_MIN_ACCESS_CYCLES 2
`define HP_ASYNC_CS_LOW_MIN 2
`define HP_ASYNC_CS_HIGH_MIN 2
`define HP_ASYNC_CS_PERIOD_MIN 4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define HP_WAIT_RESET 1'b1
`define HP_ADDR_RESET 5'h00
`define HP_DATA_RESET 16'h0000

`endif

//--- rtl/token_skid_buffer.v
/*
  Two-entry valid/ready buffer for token words.
  Assumes one clock, synchronous active-high reset, both sides on core_clk.
*/
`timescale 1ns/1ps
`include "host_port_regs.vh"

module token_skid_buffer (
  input wire core_clk,
  input wire rst,
  input wire [`HP_TOKEN_W-1:0] in_word,
  input wire in_valid,
  output wire in_ready,
  output wire [`HP_TOKEN_W-1:0] out_word,
  output wire out_valid,
  input wire out_ready
);

  reg [`HP_TOKEN_W-1:0] slot [0:1];
  reg rd_ptr;
  reg wr_ptr;
  reg [1:0] count;
  wire push;
  wire pop;

  // ----------------------------------------------------------------
  // Honest flags: ready only while a slot is free
  // ----------------------------------------------------------------
  assign in_ready = (count != 2'd2);
  assign out_valid = (count != 2'd0);
  assign out_word = slot[rd_ptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Pointers and occupancy
  always @(posedge core_clk) begin
    if (rst) begin
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
      count <= 2'd0;
    end else begin
      if (push) begin
        slot[wr_ptr] <= in_word;
        wr_ptr <= ~wr_ptr;
      end
      if (pop)
        rd_ptr <= ~rd_ptr;
      case ({push, pop})
        2'b10: count <= count + 2'd1;
        2'b01: count <= count - 2'd1;
        default: count <= count;
      endcase
    end
  end

endmodule // token_skid_buffer

//--- rtl/parallel_host_bus_interface.v
/*
  Parallel host bus port of a parallel-to-serial-link adaptor: sync and
  async access sequencing, address latching, read data enable, and the
  transmit/receive token ports with a two-entry buffer on each path.
  Assumes the internal register file answers int_done some cycles after
  int_req, and that all bus pins are asynchronous to core_clk in async mode.
*/
`timescale 1ns/1ps
`include "host_port_regs.vh"

module parallel_host_bus_interface (
  input wire core_clk,
  input wire rst,
  input wire sync_mode,
  input wire chip_select_n,
  input wire address_latch_enable,
  input wire read_write_select,
  input wire [`HP_ADDR_W-1:0] host_address,
  input wire [`HP_DATA_W-1:0] host_write_data,
  input wire host_read_output_enable_n,
  output reg host_wait,
  output reg [`HP_DATA_W-1:0] host_read_data,
  output reg host_read_data_oe,
  output reg int_req,
  output reg int_read,
  output reg [`HP_ADDR_W-1:0] int_address,
  output reg [`HP_DATA_W-1:0] int_write_data,
  input wire int_done,
  input wire [`HP_DATA_W-1:0] int_read_data,
  input wire [`HP_TOKEN_W-1:0] tx_token_word,
  input wire tx_token_is_control,
  input wire tx_token_valid,
  output reg tx_token_stall,
  output reg [`HP_TOKEN_W-2:0] tx_core_word,
  output reg tx_core_is_control,
  output reg tx_core_valid,
  input wire tx_core_ready,
  output reg [`HP_TOKEN_W-2:0] rx_token_word,
  output reg rx_token_is_control,
  output reg rx_token_valid,
  input wire rx_token_stall,
  input wire rx_token_output_enable_n,
  output reg rx_token_word_oe,
  input wire [`HP_TOKEN_W-2:0] rx_core_word,
  input wire rx_core_is_control,
  input wire rx_core_valid,
  output reg rx_core_ready
);

  // ----------------------------------------------------------------
  // State encodings (one-hot)
  // ----------------------------------------------------------------
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_FIRST = 4'b0010;
  localparam [3:0] ST_BUSY = 4'b0100;
  localparam [3:0] ST_END = 4'b1000;

  reg [3:0] state;
  reg [3:0] next_state;

  // ----------------------------------------------------------------
  // Pin synchronisers (async mode inputs)
  // ----------------------------------------------------------------
  reg cs_meta, cs_sync, cs_prev;
  reg ale_meta, ale_sync, ale_prev;
  reg oe_meta, oe_sync;
  reg rxoe_meta, rxoe_sync;

  // Two stages before logic looks at select, latch enable or an output enable, except raw select and latch enable in sync mode
  always @(posedge core_clk) begin
    if (rst) begin
      cs_meta <= 1'b1;
      cs_sync <= 1'b1;
      cs_prev <= 1'b1;
      ale_meta <= 1'b0;
      ale_sync <= 1'b0;
      ale_prev <= 1'b0;
      oe_meta <= 1'b1;
      oe_sync <= 1'b1;
      rxoe_meta <= 1'b1;
      rxoe_sync <= 1'b1;
    end else begin
      cs_meta <= chip_select_n;
      cs_sync <= cs_meta;
      cs_prev <= cs_sync;
      ale_meta <= address_latch_enable;
      ale_sync <= ale_meta;
      ale_prev <= ale_sync;
      oe_meta <= host_read_output_enable_n;
      oe_sync <= oe_meta;
      rxoe_meta <= rx_token_output_enable_n;
      rxoe_sync <= rxoe_meta;
    end
  end

  // Effective chip select: raw in sync mode, synchronised in async mode
  wire cs_low = sync_mode ? ~chip_select_n : ~cs_sync;
  wire cs_fall = sync_mode ? ~chip_select_n : (~cs_sync & cs_prev);
  wire ale_fall = ~ale_sync & ale_prev;
  // Capture in the start cycle itself: the latch below only shows it one edge later
  wire addr_capture = (sync_mode & address_latch_enable) | (~sync_mode & cs_fall & ale_sync);

  // ----------------------------------------------------------------
  // Address latch; does not start anything on its own
  // ----------------------------------------------------------------
  reg [`HP_ADDR_W-1:0] addr_hold;

  // Async capture uses the raw bus, held stable by the host around the edge
  always @(posedge core_clk) begin
    if (rst)
      addr_hold <= `HP_ADDR_RESET;
    else if (sync_mode & address_latch_enable)
      addr_hold <= host_address;
    else if (~sync_mode & cs_sync & ale_fall)
      addr_hold <= host_address;
    else if (~sync_mode & cs_fall & ale_sync)
      addr_hold <= host_address;
  end

  // ----------------------------------------------------------------
  // Access sequencer
  // ----------------------------------------------------------------
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: if (cs_fall) next_state = ST_FIRST;
      ST_FIRST: next_state = ST_BUSY;
      ST_BUSY: if (int_done) next_state = ST_END;
      ST_END: next_state = cs_low ? ST_END : ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  // Wait goes low for exactly one cycle after the internal access
  always @(posedge core_clk) begin
    if (rst) begin
      state <= ST_IDLE;
      host_wait <= `HP_WAIT_RESET;
      int_req <= 1'b0;
      int_read <= 1'b0;
      int_address <= `HP_ADDR_RESET;
      int_write_data <= `HP_DATA_RESET;
      host_read_data <= `HP_DATA_RESET;
    end else begin
      state <= next_state;
      int_req <= 1'b0;
      host_wait <= 1'b1;
      if (state == ST_IDLE && cs_fall) begin
        int_address <= addr_capture ? host_address : addr_hold;
        int_read <= read_write_select;
      end
      if (state == ST_FIRST)
        int_req <= 1'b1;
      if (state == ST_BUSY && int_done) begin
        host_wait <= 1'b0;
        if (int_read)
          host_read_data <= int_read_data;
      end
      // Write data sampled in the completing cycle only; later END cycles may see stale bus
      if (state == ST_END && ~host_wait && ~int_read)
        int_write_data <= host_write_data;
    end
  end

  // Read data driven while enabled; holds past chip select high
  always @(posedge core_clk) begin
    if (rst)
      host_read_data_oe <= 1'b0;
    else if (state == ST_FIRST)
      host_read_data_oe <= 1'b0;
    else
      host_read_data_oe <= int_read & ~oe_sync;
  end

  // ----------------------------------------------------------------
  // Token ports through two-entry buffers
  // ----------------------------------------------------------------
  wire tx_in_ready, tx_out_valid, rx_in_ready, rx_out_valid;
  wire [`HP_TOKEN_W-1:0] tx_out_word, rx_out_word;
  wire tx_pop = ~tx_core_valid | tx_core_ready;
  wire rx_pop = ~rx_token_valid | ~rx_token_stall;

  token_skid_buffer tx_buffer (
    .core_clk(core_clk),
    .rst(rst),
    .in_word({tx_token_is_control, tx_token_word[`HP_TOKEN_W-2:0]}),
    .in_valid(tx_token_valid & ~tx_token_stall),
    .in_ready(tx_in_ready),
    .out_word(tx_out_word),
    .out_valid(tx_out_valid),
    .out_ready(tx_pop)
  );

  token_skid_buffer rx_buffer (
    .core_clk(core_clk),
    .rst(rst),
    .in_word({rx_core_is_control, rx_core_word}),
    .in_valid(rx_core_valid & rx_core_ready),
    .in_ready(rx_in_ready),
    .out_word(rx_out_word),
    .out_valid(rx_out_valid),
    .out_ready(rx_pop)
  );

  // Registered stalls: assert a cycle early, so a full buffer never loses a word
  always @(posedge core_clk) begin
    if (rst) begin
      tx_token_stall <= 1'b1;
      rx_core_ready <= 1'b0;
      tx_core_valid <= 1'b0;
      tx_core_word <= 8'h00;
      tx_core_is_control <= 1'b0;
      rx_token_valid <= 1'b0;
      rx_token_word <= 8'h00;
      rx_token_is_control <= 1'b0;
      rx_token_word_oe <= 1'b0;
    end else begin
      tx_token_stall <= ~tx_in_ready | (tx_token_valid & ~tx_token_stall);
      rx_core_ready <= rx_in_ready & ~(rx_core_valid & rx_core_ready);
      if (~tx_core_valid | tx_core_ready) begin
        tx_core_valid <= tx_out_valid;
        tx_core_word <= tx_out_word[`HP_TOKEN_W-2:0];
        tx_core_is_control <= tx_out_word[`HP_TOKEN_CTRL_BIT];
      end
      if (rx_pop) begin
        rx_token_valid <= rx_out_valid;
        rx_token_word <= rx_out_word[`HP_TOKEN_W-2:0];
        rx_token_is_control <= rx_out_word[`HP_TOKEN_CTRL_BIT];
      end
      rx_token_word_oe <= ~rxoe_sync;
    end
  end

endmodule // parallel_host_bus_interface

//--- testbench/host_port_monitor.sv
/* Checker for the host port outputs.
   Assumes bind to every parallel_host_bus_interface. */
`timescale 1ns/1ps
module host_port_monitor (
  input wire core_clk,
  input wire rst,
  input wire sync_mode,
  input wire chip_select_n,
  input wire host_wait,
  input wire [15:0] host_read_data,
  input wire int_req,
  input wire int_read,
  input wire int_done,
  input wire [15:0] int_read_data,
  input wire tx_token_valid,
  input wire tx_token_stall,
  input wire [7:0] rx_token_word,
  input wire rx_token_valid,
  input wire rx_token_stall
);
  // One clock, so one default; quiet in reset
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_first_cycle_wait: assert property ($fell(chip_select_n) |-> host_wait [*2])
    else $error("wait low in first cycle");
  a_sync_start_req: assert property (sync_mode && $fell(chip_select_n) |-> ##[1:3] int_req)
    else $error("no internal request");
  a_ale_no_start: assert property (chip_select_n [*3] |-> !int_req)
    else $error("request without select");
  a_done_ends_wait: assert property (int_done |=> !host_wait)
    else $error("wait not lowered");
  a_wait_low_once: assert property (!host_wait |=> host_wait)
    else $error("wait low too long");
  a_read_data_out: assert property (int_done && int_read |=> host_read_data == $past(int_read_data))
    else $error("read data wrong");
  a_read_data_hold: assert property (host_wait |-> $stable(host_read_data))
    else $error("read data moved");
  a_tx_take_stall: assert property (tx_token_valid && !tx_token_stall |=> tx_token_stall)
    else $error("no stall after take");
  a_rx_word_hold: assert property (rx_token_valid && rx_token_stall |=> rx_token_valid && $stable(rx_token_word))
    else $error("rx word dropped");
endmodule // host_port_monitor

bind parallel_host_bus_interface host_port_monitor u_mon (.core_clk, .rst, .sync_mode, .chip_select_n,
  .host_wait, .host_read_data, .int_req, .int_read, .int_done, .int_read_data, .tx_token_valid,
  .tx_token_stall, .rx_token_word, .rx_token_valid, .rx_token_stall);

//--- testbench/internal_store_model.sv
/* Model of the internal store behind the host port.
   Assumes one request at a time; delay of zero never answers. */
`timescale 1ns/1ps
module internal_store_model (
  input wire core_clk,
  input wire rst,
  input wire int_req,
  input wire [4:0] int_address,
  input wire [3:0] delay,
  output reg int_done,
  output reg [15:0] int_read_data
);
  reg [3:0] cnt;
  // Data only valid with done; toggles otherwise so no stale value passes
  always @(posedge core_clk) begin
    int_done <= 1'b0;
    int_read_data <= ~int_read_data;
    if (rst) begin
      cnt <= 4'h0;
      int_read_data <= 16'h0000;
    end else if (int_req) begin
      cnt <= delay;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
      if (cnt == 4'h1) begin
        int_done <= 1'b1;
        int_read_data <= {11'h000, int_address} ^ 16'hc3a5;
      end
    end
  end
endmodule // internal_store_model

//--- testbench/parallel_host_bus_interface_tb.sv
/* Self-checking bench for the host port.
   Assumes the store model answers internal requests. */
`timescale 1ns/1ps
module parallel_host_bus_interface_tb;
  reg core_clk = 1'b0, rst = 1'b1, sync_mode = 1'b1, chip_select_n = 1'b1, address_latch_enable = 1'b1;
  reg read_write_select = 1'b1, host_read_output_enable_n = 1'b1, rx_token_stall = 1'b1, on = 1'b0;
  reg tx_token_is_control = 1'b0, tx_token_valid = 1'b0, tx_core_ready = 1'b0, rx_token_output_enable_n = 1'b0;
  reg rx_core_valid = 1'b0, rx_core_is_control = 1'b0;
  reg [4:0] host_address = 5'h00;
  reg [15:0] host_write_data = 16'h0000, last = 16'h0000;
  reg [8:0] tx_token_word = 9'h000;
  reg [7:0] rx_core_word = 8'h00, tx_got = 8'h00, rx_got = 8'h00, scnt = 8'h00;
  reg [3:0] dly = 4'h1;
  reg [11:0] rows [0:5];
  wire host_wait, host_read_data_oe, int_req, int_read, int_done, tx_token_stall, tx_core_is_control;
  wire tx_core_valid, rx_token_is_control, rx_token_valid, rx_token_word_oe, rx_core_ready;
  wire [4:0] int_address;
  wire [15:0] host_read_data, int_write_data, int_read_data;
  wire [7:0] tx_core_word, rx_token_word;
  integer err_count = 0, tests_run = 0, i;

  parallel_host_bus_interface u_dut (.core_clk, .rst, .sync_mode, .chip_select_n, .address_latch_enable,
    .read_write_select, .host_address, .host_write_data, .host_read_output_enable_n, .host_wait,
    .host_read_data, .host_read_data_oe, .int_req, .int_read, .int_address, .int_write_data, .int_done,
    .int_read_data, .tx_token_word, .tx_token_is_control, .tx_token_valid, .tx_token_stall, .tx_core_word,
    .tx_core_is_control, .tx_core_valid, .tx_core_ready, .rx_token_word, .rx_token_is_control,
    .rx_token_valid, .rx_token_stall, .rx_token_output_enable_n, .rx_token_word_oe, .rx_core_word,
    .rx_core_is_control, .rx_core_valid, .rx_core_ready);
  internal_store_model u_store (.core_clk, .rst, .int_req, .int_address, .delay(dly), .int_done, .int_read_data);

  // 40 MHz core clock
  always #12.5 core_clk = ~core_clk;

  task chk16(input [15:0] g, input [15:0] e);
    begin
      tests_run = tests_run + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("Error t=%0t got %h exp %h", $time, g, e);
      end
    end
  endtask

  task chk1(input g, input e);
    begin
      chk16({15'h0000, g}, {15'h0000, e});
    end
  endtask

  // One bus access; host holds select, direction and write data until wait is seen low; with ale_p it drops latch enable and moves the address
  task bus_access(input s, input rw, input ale_p, input [4:0] a, input [3:0] d);
    integer n;
    begin
      sync_mode <= s;
      dly <= d;
      @(posedge core_clk);
      chip_select_n <= 1'b0;
      read_write_select <= rw;
      host_address <= a;
      host_write_data <= {a, 11'h155};
      n = 0;
      while (host_wait !== 1'b0 && n < 60) begin
        @(posedge core_clk);
        n = n + 1;
        if (ale_p) begin
          address_latch_enable <= 1'b0;
          host_address <= ~a;
        end
        if (int_req === 1'b1) begin
          chk16({11'h000, int_address}, {11'h000, a});
          chk1(int_read, rw);
        end
      end
      chk1(n > 2 && n < 60, 1'b1);
      last = rw ? {11'h000, a} ^ 16'hc3a5 : last;
      if (rw) chk16(host_read_data, last);
      chip_select_n <= 1'b1;
      address_latch_enable <= 1'b1;
      @(posedge core_clk);
      if (!rw) chk16(int_write_data, {a, 11'h155});
      repeat (2) @(posedge core_clk);
    end
  endtask

  // Tokens both ways; sinks stall first so both buffers fill
  always @(posedge core_clk) begin
    if (on) scnt <= scnt + 8'h01;
    tx_token_valid <= on && tx_token_word < 9'd12;
    rx_core_valid <= on && rx_core_word < 8'd12;
    tx_core_ready <= scnt > 8'd10 && scnt[0];
    rx_token_stall <= !(scnt > 8'd10 && scnt[1]);
    if (tx_token_valid && !tx_token_stall) begin
      tx_token_word <= tx_token_word + 9'h001;
      tx_token_is_control <= !tx_token_word[0];
    end
    if (rx_core_valid && rx_core_ready) begin
      rx_core_word <= rx_core_word + 8'h01;
      rx_core_is_control <= !rx_core_word[0];
    end
    if (tx_core_valid && tx_core_ready) begin
      chk16({tx_core_is_control, 7'h00, tx_core_word}, {tx_got[0], 7'h00, tx_got});
      tx_got = tx_got + 8'h01;
    end
    if (rx_token_valid && !rx_token_stall) begin
      chk16({rx_token_is_control, 7'h00, rx_token_word}, {rx_got[0], 7'h00, rx_got});
      rx_got = rx_got + 8'h01;
    end
  end

  task complete_run;
    begin
      $display("errors %0d checks %0d", err_count, tests_run);
      if (err_count == 0 && tests_run > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask

  // Whole run is a few hundred cycles
  initial begin
    #125000;
    err_count = err_count + 1;
    complete_run;
  end

  // Reset, table of accesses, then hand-written cases
  initial begin
    rows[0] = {3'b110, 5'h05, 4'h1};
    rows[1] = {3'b100, 5'h0a, 4'h2};
    rows[2] = {3'b111, 5'h1f, 4'h7};
    rows[3] = {3'b110, 5'h00, 4'h3};
    rows[4] = {3'b000, 5'h04, 4'h4};
    rows[5] = {3'b010, 5'h13, 4'h1};
    repeat (5) @(posedge core_clk);
    chk1(host_wait, 1'b1);
    chk1(tx_token_stall, 1'b1);
    chk1(int_req, 1'b0);
    rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    for (i = 0; i < 6; i = i + 1)
      bus_access(rows[i][11], rows[i][10], rows[i][9], rows[i][8:4], rows[i][3:0]);
    repeat (6) begin
      @(posedge core_clk);
      address_latch_enable <= !address_latch_enable;
      chk1(int_req, 1'b0);
    end
    // Async: address latched on latch enable fall with select high, then bus moves
    host_address <= 5'h0b;
    @(posedge core_clk);
    address_latch_enable <= 1'b0;
    repeat (4) @(posedge core_clk);
    bus_access(1'b0, 1'b1, 1'b1, 5'h0b, 4'h2);
    host_read_output_enable_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk1(host_read_data_oe, 1'b1);
    chk16(host_read_data, last);
    chk1(rx_token_word_oe, 1'b1);
    host_read_output_enable_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk1(host_read_data_oe, 1'b0);
    on <= 1'b1;
    while (scnt != 8'd9) @(posedge core_clk);
    chk1(tx_token_stall, 1'b1);
    chk1(rx_core_ready, 1'b0);
    repeat (80) @(posedge core_clk);
    chk16({8'h00, tx_got}, 16'h000c);
    chk16({8'h00, rx_got}, 16'h000c);
    complete_run;
  end
endmodule // parallel_host_bus_interface_tb
